// >>> rtl/adcseq_cfg.svh
/*
 Offsets, field positions, reset values and timing counts of the converter control block.
 Assumes inclusion by bare name from design files only.
*/
`ifndef ADCSEQ_CFG_SVH
`define ADCSEQ_CFG_SVH
// Offsets are register indices; byte address is four times the index
`define ADCSEQ_IDX_RESULT 8'hd0
`define ADCSEQ_IDX_CONTROL 8'hd1
`define ADCSEQ_IDX_IRQ_STATUS 8'hd2
`define ADCSEQ_IDX_IRQ_MASK 8'hd3
`define ADCSEQ_BIT_IRQ_EN 7
`define ADCSEQ_BIT_DONE 6
`define ADCSEQ_BIT_START 5
`define ADCSEQ_BIT_POWER 4
`define ADCSEQ_BIT_OSC_OFF 2
`define ADCSEQ_CTL_RESET 8'h40
`define ADCSEQ_CTL_WMASK 8'h94
// Conversion time in ns at a reference clock of 8 MHz
`define ADCSEQ_CONV_NS 70000
`define ADCSEQ_REF_CLK_MHZ 8
// Cycles at the reference clock; the sequence length is fixed in cycles
`define ADCSEQ_CONV_CYC ((`ADCSEQ_CONV_NS * `ADCSEQ_REF_CLK_MHZ) / 1000)
`define ADCSEQ_STEP_CYC (`ADCSEQ_CONV_CYC / 8)
`endif

// >>> rtl/adcseq_pkg.sv
/*
 Types shared by the converter control block.
 Assumes no surroundings.
*/
`default_nettype none
package adcseq_pkg;
   typedef enum logic [1:0] {ADCSEQ_IDLE, ADCSEQ_SETTLE, ADCSEQ_STEP} adcseq_state_t;
   typedef logic [7:0] adcseq_byte_t;
endpackage
`default_nettype wire

// >>> rtl/adcseq_sar_if.sv
/*
 Carrier between register front end and approximation engine.
 Assumes both ends on one clock.
*/
`default_nettype none
interface adcseq_sar_if;
   import adcseq_pkg::*;
   logic start;
   logic enable;
   logic cmp;
   adcseq_byte_t trial;
   adcseq_byte_t code;
   logic done;
   logic busy;
   modport ctl (output start, output enable, input trial, input code, input done, input busy);
   modport eng (input start, input enable, input cmp, output trial, output code, output done, output busy);
endinterface
`default_nettype wire

// >>> rtl/adcseq_engine.sv
/*
 Successive approximation engine: eight steps, most significant bit first.
 Assumes the comparator input is synchronous and high when the input exceeds the trial code.
*/
`include "adcseq_cfg.svh"
`default_nettype none
module adcseq_engine
   import adcseq_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   adcseq_sar_if.eng sar
);
   localparam int STEP_CYC = `ADCSEQ_STEP_CYC;
   adcseq_state_t state_q, state_d;
   logic [9:0] cnt_q, cnt_d;
   logic [2:0] bit_q, bit_d;
   adcseq_byte_t trial_q, trial_d, code_q, code_d;
   logic done_q, done_d;

   // Next state; while enabled, a start restarts from the top bit
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      bit_d = bit_q;
      trial_d = trial_q;
      code_d = code_q;
      done_d = 1'b0;
      if (!sar.enable) begin
         state_d = ADCSEQ_IDLE; // Powered off or stopped
      end else if (sar.start) begin
         state_d = ADCSEQ_STEP;
         cnt_d = 10'(STEP_CYC - 1); // Fixed cycles per step
         bit_d = 3'd7;
         trial_d = 8'h80;
      end else if (state_q == ADCSEQ_STEP) begin
         if (cnt_q != 10'h000) begin
            cnt_d = cnt_q - 10'h001;
         end else begin
            // Keep the bit when input is above trial; saturates at ff and 00
            trial_d = trial_q & ~(sar.cmp ? 8'h00 : (8'h01 << bit_q));
            cnt_d = 10'(STEP_CYC - 1);
            if (bit_q == 3'd0) begin
               code_d = trial_q & ~(sar.cmp ? 8'h00 : 8'h01);
               done_d = 1'b1;
               state_d = ADCSEQ_IDLE;
            end else begin
               bit_d = bit_q - 3'd1;
               trial_d = (trial_q & ~(sar.cmp ? 8'h00 : (8'h01 << bit_q))) | (8'h01 << (bit_q - 3'd1));
            end
         end
      end
   end

   // Registers
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= ADCSEQ_IDLE;
         cnt_q <= 10'h000;
         bit_q <= 3'd7;
         trial_q <= 8'h00;
         code_q <= 8'h00;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         bit_q <= bit_d;
         trial_q <= trial_d;
         code_q <= code_d;
         done_q <= done_d;
      end
   end

   assign sar.trial = trial_q;
   assign sar.code = code_q;
   assign sar.done = done_q;
   assign sar.busy = (state_q == ADCSEQ_STEP);
endmodule
`default_nettype wire

// >>> rtl/adcseq_top.sv
/*
 Converter control sequencer: Avalon-MM register slave, control and result registers,
 sticky interrupt status with mask, wake output, and the approximation engine.
 Assumes a synchronous comparator input and synchronous low power mode inputs.
*/
`include "adcseq_cfg.svh"
`default_nettype none
module adcseq_top
   import adcseq_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic [9:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic [1:0] avs_response_out,
   input wire logic cmp_in,
   input wire logic wait_mode_in,
   input wire logic stop_mode_in,
   output logic conv_irq_out,
   output logic wake_out,
   output logic main_osc_disable_out,
   output logic conv_power_on_out
);
   adcseq_sar_if sar();

   // Control fields
   localparam adcseq_byte_t CTL_RST = `ADCSEQ_CTL_RESET;
   logic conv_irq_enable_q, conv_irq_enable_d;
   logic done_q, done_d;
   logic conv_power_on_q, conv_power_on_d;
   logic main_osc_disable_q, main_osc_disable_d;
   logic [1:0] ev_stat_q, ev_stat_d;
   logic [1:0] ev_mask_q, ev_mask_d;
   logic start_q, start_d;
   // Bus answer registers
   logic ack_q, ack_d;
   logic waitreq_q, waitreq_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] resp_q, resp_d;
   logic irq_q, irq_d, wake_q, wake_d;

   function automatic logic is_reg(input logic [9:0] a, input logic [7:0] idx);
      is_reg = (a[9:2] == idx) && (a[1:0] == 2'b00);
   endfunction

   logic wr_ctl, start_req, hit;
   adcseq_byte_t ctl_view;

   // Decode; byte lane 0 carries all register bits
   always_comb begin
      wr_ctl = avs_write_in && !ack_q && avs_byteenable_in[0] && is_reg(avs_address_in, `ADCSEQ_IDX_CONTROL);
      start_req = wr_ctl && avs_writedata_in[`ADCSEQ_BIT_START];
      hit = is_reg(avs_address_in, `ADCSEQ_IDX_RESULT) || is_reg(avs_address_in, `ADCSEQ_IDX_CONTROL)
         || is_reg(avs_address_in, `ADCSEQ_IDX_IRQ_STATUS) || is_reg(avs_address_in, `ADCSEQ_IDX_IRQ_MASK);
      ctl_view = 8'h00; // Start and reserved bits read zero
      ctl_view[`ADCSEQ_BIT_IRQ_EN] = conv_irq_enable_q;
      ctl_view[`ADCSEQ_BIT_DONE] = done_q;
      ctl_view[`ADCSEQ_BIT_POWER] = conv_power_on_q;
      ctl_view[`ADCSEQ_BIT_OSC_OFF] = main_osc_disable_q;
   end

   // Control and flag next values
   always_comb begin
      conv_irq_enable_d = conv_irq_enable_q;
      conv_power_on_d = conv_power_on_q;
      main_osc_disable_d = main_osc_disable_q;
      ev_mask_d = ev_mask_q;
      ev_stat_d = ev_stat_q;
      done_d = done_q;
      start_d = start_req;
      if (wr_ctl) begin
         // Done flag ignores written data reserved bits are not stored
         conv_irq_enable_d = avs_writedata_in[`ADCSEQ_BIT_IRQ_EN];
         conv_power_on_d = avs_writedata_in[`ADCSEQ_BIT_POWER];
         main_osc_disable_d = avs_writedata_in[`ADCSEQ_BIT_OSC_OFF];
      end
      if (start_req) begin
         done_d = 1'b0;
      end
      if (sar.done) begin
         done_d = 1'b1; // Loaded with the result
      end
      if (avs_write_in && !ack_q && avs_byteenable_in[0] && is_reg(avs_address_in, `ADCSEQ_IDX_IRQ_MASK)) begin
         ev_mask_d = avs_writedata_in[1:0];
      end
      if (avs_write_in && !ack_q && avs_byteenable_in[0] && is_reg(avs_address_in, `ADCSEQ_IDX_IRQ_STATUS)) begin
         ev_stat_d = ev_stat_q & ~avs_writedata_in[1:0];
      end
      // Set wins over a clear in the same cycle; bit0 done, bit1 start
      ev_stat_d = ev_stat_d | {start_req, sar.done};
   end

   // Interrupt: level from enable and done, or from unmasked sticky events
   always_comb begin
      irq_d = (conv_irq_enable_d && done_d) || |(ev_stat_d & ev_mask_d);
      // Wake from wait only; in stop the converter halts and cannot wake
      wake_d = irq_d && wait_mode_in && !stop_mode_in;
   end

   // Bus answer: one wait state, then ack with data
   always_comb begin
      ack_d = (avs_read_in || avs_write_in) && !ack_q;
      waitreq_d = !ack_d; // Registered so the pin comes straight from a flop
      rdata_d = 32'h0000_0000;
      resp_d = hit ? 2'b00 : 2'b10; // Unmapped answers slave error
      if (is_reg(avs_address_in, `ADCSEQ_IDX_RESULT)) begin
         rdata_d[7:0] = sar.code;
      end else if (is_reg(avs_address_in, `ADCSEQ_IDX_CONTROL)) begin
         rdata_d[7:0] = ctl_view;
      end else if (is_reg(avs_address_in, `ADCSEQ_IDX_IRQ_STATUS)) begin
         rdata_d[1:0] = ev_stat_q;
      end else if (is_reg(avs_address_in, `ADCSEQ_IDX_IRQ_MASK)) begin
         rdata_d[1:0] = ev_mask_q;
      end
   end

   // Registers
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         conv_irq_enable_q <= CTL_RST[`ADCSEQ_BIT_IRQ_EN]; // 40h after reset
         done_q <= CTL_RST[`ADCSEQ_BIT_DONE];
         conv_power_on_q <= CTL_RST[`ADCSEQ_BIT_POWER];
         main_osc_disable_q <= CTL_RST[`ADCSEQ_BIT_OSC_OFF];
         ev_stat_q <= 2'b00;
         ev_mask_q <= 2'b00;
         start_q <= 1'b0;
         ack_q <= 1'b0;
         waitreq_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
         resp_q <= 2'b00;
         irq_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         conv_irq_enable_q <= conv_irq_enable_d;
         done_q <= done_d;
         conv_power_on_q <= conv_power_on_d;
         main_osc_disable_q <= main_osc_disable_d;
         ev_stat_q <= ev_stat_d;
         ev_mask_q <= ev_mask_d;
         start_q <= start_d;
         ack_q <= ack_d;
         waitreq_q <= waitreq_d;
         rdata_q <= rdata_d;
         resp_q <= resp_d;
         irq_q <= irq_d;
         wake_q <= wake_d;
      end
   end

   // Engine runs in wait, halts when powered off or stopped
   assign sar.start = start_q;
   assign sar.enable = conv_power_on_q && !stop_mode_in;
   assign sar.cmp = cmp_in;

   adcseq_engine u_engine (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .sar(sar)
   );

   assign avs_readdata_out = rdata_q;
   assign avs_waitrequest_out = waitreq_q;
   assign avs_response_out = resp_q;
   assign conv_irq_out = irq_q;
   assign wake_out = wake_q;
   assign main_osc_disable_out = main_osc_disable_q;
   assign conv_power_on_out = conv_power_on_q;
endmodule
`default_nettype wire

// >>> verification/adcseq_analog_model.sv
/*
 Analog source with comparator, standing in front of the converter.
 Assumes rail levels only, since the trial code stays inside the design.
*/
`default_nettype none
module adcseq_analog_model (
   input wire logic rail_high_in,
   output logic cmp_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // Top rail beats every trial and the bottom rail none; mid levels need the hidden trial
   assign cmp_out = rail_high_in;
endmodule
`default_nettype wire

// >>> verification/adcseq_asserts.sv
/*
 Assertions on the register port and control outputs of the sequencer.
 Assumes binding to adcseq_top on its single clock.
*/
`default_nettype none
module adcseq_asserts (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic [9:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic [1:0] avs_response_out,
   input wire logic stop_mode_in,
   input wire logic wake_out,
   input wire logic main_osc_disable_out,
   input wire logic conv_power_on_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Acked access decode
   wire logic ack = !avs_waitrequest_out && (avs_read_in || avs_write_in);
   wire logic mapped = avs_address_in inside {10'h340, 10'h344, 10'h348, 10'h34c};
   wire logic wc = ack && avs_write_in && avs_address_in == 10'h344 && avs_byteenable_in[0];
   chk_ack_next: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("ack late");
   chk_ack_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("ack too long");
   chk_start_zero: assert property (ack && avs_read_in && avs_address_in == 10'h344 |-> !avs_readdata_out[5])
      else $error("start bit read back");
   chk_upper_zero: assert property (ack && avs_read_in |-> avs_readdata_out[31:8] == 24'h0)
      else $error("upper read bits set");
   chk_unmapped_err: assert property (ack && !mapped |-> avs_response_out == 2'b10 && (avs_write_in || avs_readdata_out == 32'h0))
      else $error("unmapped answer wrong");
   chk_mapped_ok: assert property (ack && mapped |-> avs_response_out == 2'b00)
      else $error("mapped answer wrong");
   chk_power_copy: assert property (wc && avs_writedata_in[4] |-> ##[1:2] conv_power_on_out)
      else $error("power stays off");
   chk_osc_copy: assert property (wc && !avs_writedata_in[2] |-> ##[1:2] !main_osc_disable_out)
      else $error("oscillator stays off");
   chk_stop_wake: assert property (stop_mode_in && $past(stop_mode_in) |-> !wake_out)
      else $error("wake in stop");
   cover property (wc && avs_writedata_in[5]);
   cover property (wake_out);
   cover property (ack && !mapped);
endmodule
bind adcseq_top adcseq_asserts adcseq_asserts_inst (.core_clk_in, .rst_n_in, .avs_address_in, .avs_read_in,
   .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
   .avs_response_out, .stop_mode_in, .wake_out, .main_osc_disable_out, .conv_power_on_out);
`default_nettype wire

// >>> verification/tb_top.sv
/*
 Self-checking bench for the converter control sequencer.
 Assumes the analog model on the comparator input and the bound checker.
*/
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk_in = 1'b0, rst_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
   logic [9:0] avs_address_in = 10'h0;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
   logic [3:0] avs_byteenable_in = 4'hf;
   logic avs_waitrequest_out, cmp_in, rail_high = 1'b1, wait_mode_in = 1'b0, stop_mode_in = 1'b0;
   logic [1:0] avs_response_out;
   logic conv_irq_out, wake_out, main_osc_disable_out, conv_power_on_out;
   logic [7:0] q, v;
   int mismatches = 0, check_count = 0, cyc = 0, seed = 965, t, t0;
   // Clock and cycle count
   always #4 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) cyc <= cyc + 1;
   adcseq_top adcseq_top_inst (.core_clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
      .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .avs_response_out,
      .cmp_in, .wait_mode_in, .stop_mode_in, .conv_irq_out, .wake_out, .main_osc_disable_out, .conv_power_on_out);
   adcseq_analog_model adcseq_analog_model_inst (.rail_high_in(rail_high), .cmp_out(cmp_in));
   task automatic report_and_stop;
      if (mismatches == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   // One Avalon transfer; held until waitrequest is sampled low at a rising edge, data taken there
   task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk_in);
      avs_address_in <= a;
      avs_writedata_in <= {24'h0, d};
      avs_write_in <= w;
      avs_read_in <= !w;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 100);
      if (avs_waitrequest_out !== 1'b0) begin
         mismatches++;
         report_and_stop();
      end else begin
         q = avs_readdata_out[7:0];
         avs_write_in <= 1'b0;
         avs_read_in <= 1'b0;
      end
   endtask
   // Poll the done flag, bounded so a stuck engine ends the run
   task automatic wait_done;
      do bus(1'b0, 10'h344, 8'h0);
      while (q[6] !== 1'b1 && cyc - t0 < 3000);
      t = cyc - t0;
      chk("done", 8'(q[6]), 8'h1);
      if (q[6] !== 1'b1)
         report_and_stop();
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      bus(1'b0, 10'h344, 8'h0); chk("ctl_reset", q, 8'h40);
      bus(1'b0, 10'h348, 8'h0); chk("status_reset", q, 8'h00);
      bus(1'b0, 10'h34c, 8'h0); chk("mask_reset", q, 8'h00);
      bus(1'b0, 10'h3fc, 8'h0); chk("unmapped", q, 8'h00);
      // Random legal control values; reserved bits held clear, done written as zero
      for (int i = 0; i < 8; i++) begin
         v = 8'($random(seed)) & 8'h94;
         bus(1'b1, 10'h344, v);
         bus(1'b1, 10'h340, ~v);
         bus(1'b0, 10'h340, 8'h0); chk("result_ro", q, 8'h00);
         bus(1'b0, 10'h344, 8'h0); chk("ctl_rw", q, v | 8'h40);
         chk("power_out", 8'(conv_power_on_out), 8'(v[4]));
         chk("osc_out", 8'(main_osc_disable_out), 8'(v[2]));
         chk("irq_en_done", 8'(conv_irq_out), 8'(v[7]));
      end
      // Lane 0 off: the write must leave the control bits alone
      avs_byteenable_in <= 4'he;
      bus(1'b1, 10'h344, ~v & 8'h94);
      avs_byteenable_in <= 4'hf;
      bus(1'b0, 10'h344, 8'h0); chk("lane_off", q, v | 8'h40);
      // Power on first, start later; conversion at the top rail
      bus(1'b1, 10'h344, 8'h10);
      t0 = cyc;
      bus(1'b1, 10'h344, 8'h30);
      bus(1'b0, 10'h344, 8'h0); chk("start_clears", q, 8'h10);
      wait_done();
      chk("conv_time", 8'(t >= 557 && t <= 575), 8'h1);
      bus(1'b0, 10'h340, 8'h0); chk("top_rail", q, 8'hff);
      bus(1'b0, 10'h348, 8'h0); chk("events", q, 8'h03);
      // Masked status raises the line; writing ones clears it
      bus(1'b1, 10'h34c, 8'h01);
      @(negedge core_clk_in); chk("irq_mask", 8'(conv_irq_out), 8'h1);
      bus(1'b1, 10'h348, 8'h03);
      @(negedge core_clk_in); chk("irq_clear", 8'(conv_irq_out), 8'h0);
      bus(1'b0, 10'h348, 8'h0); chk("w1c", q, 8'h00);
      // Enabled done wakes in wait mode, not in stop
      wait_mode_in <= 1'b1;
      bus(1'b1, 10'h344, 8'h90);
      repeat (2) @(negedge core_clk_in);
      chk("irq_en", 8'(conv_irq_out), 8'h1);
      chk("wake", 8'(wake_out), 8'h1);
      @(posedge core_clk_in);
      stop_mode_in <= 1'b1;
      repeat (3) @(negedge core_clk_in);
      chk("stop_wake", 8'(wake_out), 8'h0);
      @(posedge core_clk_in);
      stop_mode_in <= 1'b0;
      bus(1'b1, 10'h344, 8'h10);
      // Restart in mid conversion at the bottom rail; full length from the second start
      rail_high <= 1'b0;
      bus(1'b1, 10'h344, 8'hb0);
      chk("start_irq", 8'(conv_irq_out), 8'h0);
      repeat (100) @(posedge core_clk_in);
      t0 = cyc;
      bus(1'b1, 10'h344, 8'h30);
      wait_done();
      chk("restart_time", 8'(t >= 557 && t <= 575), 8'h1);
      bus(1'b0, 10'h340, 8'h0); chk("bottom_rail", q, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
